// [hdl/adc_reg_pkg.sv]
// Purpose: constants for the converter register set
// Assumes: 16-bit register words, 3-bit register address
// Notes: Function
// Function
// - Low power bit selects reduced-power mode
// - Amp power-down bit switches amplifier off
// - Status 15:14 return fixed part code
// - Status 13:11 return die number
// - Status bit 10 reads zero
// - Status bit 9 shows low power
// - Status bit 8 flags overrange
// - Bit 7 set when download checksum matches
// - Bit 6 set when runtime checksum matches
// - Bit 5 set while custom filter used
// - Bit 4 mirrors third stage bypass
// - Bit 3 one; bits 2:0 decimation
// - Offset at 0x003, signed, reset zero
// - Offset applied after gain
// - Gain at 0x004, 0x8000 unity, reset 0xa000
// - Threshold at 0x005 checks first filter
// - Over four full-scale modulator samples flag
// - Chip power-down bit powers converter down
// - Status read only via readback select
// - Power control at 0x002, reset 0x009b
package adc_reg_pkg;
   localparam logic [2:0] addr_ctrl1 = 3'h1;
   localparam logic [2:0] addr_power = 3'h2;
   localparam logic [2:0] addr_offset = 3'h3;
   localparam logic [2:0] addr_gain = 3'h4;
   localparam logic [2:0] addr_thresh = 3'h5;
   localparam logic [15:0] rst_ctrl1 = 16'h001a;
   localparam logic [15:0] rst_power = 16'h009b;
   localparam logic [15:0] rst_offset = 16'h0000;
   localparam logic [15:0] rst_gain = 16'ha000;
   localparam logic [15:0] rst_thresh = 16'hcccc;
   // Power control bit positions
   localparam int pwr_amp_pd = 0;
   localparam int pwr_low = 2;
   localparam int pwr_chip_pd = 3;
   // First control register bit positions
   localparam int c1_dl = 15;
   localparam int c1_rd_ovr = 14;
   localparam int c1_rd_gain = 13;
   localparam int c1_rd_off = 12;
   localparam int c1_rd_stat = 11;
   localparam int c1_zero = 10;
   localparam int c1_sync = 9;
   localparam int c1_third = 4;
   // Part code, value arbitrary
   localparam logic [1:0] part_code = 2'h1;
   // Modulator samples beyond full scale tolerated
   localparam logic [2:0] mod_over_limit = 3'h4;
   localparam int gain_shift = 15;
   typedef enum logic {wait_addr, wait_data} phase_e;
endpackage : adc_reg_pkg

// [hdl/overrange_detect.sv]
// Purpose: overrange flag from first filter and modulator
// Assumes: inputs on clk from converter logic
// Notes: flag follows each first-filter sample
`timescale 1ns/1ns
module overrange_detect
   import adc_reg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Threshold and samples
   input wire logic [15:0] threshold,
   input wire logic s1_valid,
   input wire logic signed [23:0] s1_data,
   input wire logic mod_valid,
   input wire logic mod_over_full,
   // Result
   output logic flag
);
   typedef struct packed {
      logic [2:0] run;
      logic flag;
   } st_s;
   st_s r, next_r;
   logic [23:0] mag;

   // Magnitude of the pre-gain sample, top bits against threshold
   always_comb begin
      mag = s1_data[23] ? 24'(-s1_data) : s1_data;
      next_r = r;
      if (s1_valid) begin
         next_r.flag = ({mag[22:8], 1'b0} > threshold);
      end
      if (mod_valid) begin
         if (!mod_over_full) begin
            next_r.run = 3'h0;
         end else if (r.run != 3'h7) begin
            next_r.run = r.run + 3'h1;
         end
      end
      // Set at once, whatever the threshold
      if (r.run > mod_over_limit) begin
         next_r.flag = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign flag = r.flag;
endmodule : overrange_detect

// [hdl/gain_offset_path.sv]
// Purpose: gain then offset correction of output words
// Assumes: signed 24-bit samples, gain 0x8000 is unity
// Notes: saturates to 24 bits, one cycle latency
`timescale 1ns/1ns
module gain_offset_path
   import adc_reg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Correction values
   input wire logic [15:0] gain,
   input wire logic [15:0] offset,
   input wire logic hold,
   // Sample in and out
   input wire logic in_valid,
   input wire logic signed [23:0] in_data,
   output logic out_valid,
   output logic [23:0] out_data
);
   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } st_s;
   st_s r, next_r;
   logic signed [40:0] prod;
   logic signed [41:0] sum;

   // Offset LSB equals output LSB, so it adds straight on
   always_comb begin
      prod = in_data * $signed({1'b0, gain});
      sum = 42'(prod >>> gain_shift) + 42'($signed(offset));
      next_r.valid = in_valid && !hold;
      next_r.data = r.data;
      if (in_valid && !hold) begin
         if (sum > 42'sh7fffff) begin
            next_r.data = 24'h7fffff;
         end else if (sum < -42'sh800000) begin
            next_r.data = 24'h800000;
         end else begin
            next_r.data = sum[23:0];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign out_valid = r.valid;
   assign out_data = r.data;
endmodule : gain_offset_path

// [hdl/adc_config_status_registers.sv]
// Purpose: control, correction and status registers
// Assumes: serial front end delivers whole 16-bit words
// Notes: address word then data word; reads via select
`timescale 1ns/1ns
module adc_config_status_registers
   import adc_reg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register words from the serial front end
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   // Read request and answer
   input wire logic read_strobe,
   output logic read_valid,
   output logic [23:0] read_data,
   // Die number pins
   input wire logic [2:0] die_pins,
   // First filter and modulator samples
   input wire logic s1_valid,
   input wire logic [23:0] s1_data,
   input wire logic mod_valid,
   input wire logic mod_over_full,
   // Final filter samples
   input wire logic filt_valid,
   input wire logic [23:0] filt_data,
   // Coefficient download
   input wire logic dl_coef_valid,
   input wire logic [31:0] dl_coef,
   input wire logic dl_sum_valid,
   input wire logic [31:0] dl_sum_word,
   // Coefficients passing through the filter
   input wire logic run_coef_valid,
   input wire logic [31:0] run_coef,
   input wire logic run_pass_done,
   // Power and control outputs
   output logic low_power_select,
   output logic amp_power_down,
   output logic chip_power_down,
   output logic third_stage_enable,
   output logic [2:0] decimation_select,
   output logic sync_pulse,
   output logic download_start,
   // Corrected conversion data
   output logic data_valid,
   output logic [23:0] data_out
);
   typedef struct packed {
      phase_e phase;
      logic [2:0] addr;
      logic [15:0] ctrl1;
      logic [15:0] power;
      logic [15:0] offset;
      logic [15:0] gain;
      logic [15:0] thresh;
      logic [2:0] die_meta;
      logic [2:0] die;
      logic [31:0] dl_sum;
      logic [31:0] run_sum;
      logic [31:0] stored_sum;
      logic download_checksum_ok;
      logic run_ok;
      logic custom;
      logic rd_valid;
      logic [23:0] rd_data;
      logic [23:0] last_conv;
      logic sync;
      logic dl_start;
   } st_s;
   st_s r, next_r;

   logic ovr_flag;
   logic conv_valid;
   logic [23:0] conv_data;
   logic [15:0] status_word;
   logic write_hit;

   // Overrange detector, before any correction
   overrange_detect u_ovr (
      .clk(clk),
      .sys_rst(sys_rst),
      .threshold(r.thresh),
      .s1_valid(s1_valid),
      .s1_data(s1_data),
      .mod_valid(mod_valid),
      .mod_over_full(mod_over_full),
      .flag(ovr_flag)
   );

   // Output correction; no new sample is taken while chip power-down is set
   gain_offset_path u_path (
      .clk(clk),
      .sys_rst(sys_rst),
      .gain(r.gain),
      .offset(r.offset),
      .hold(r.power[pwr_chip_pd]),
      .in_valid(filt_valid),
      .in_data(filt_data),
      .out_valid(conv_valid),
      .out_data(conv_data)
   );

   // Status word assembly
   always_comb begin
      status_word = 16'h0000;
      status_word[15:14] = part_code;
      status_word[13:11] = r.die;
      status_word[10] = 1'b0;
      status_word[9] = r.power[pwr_low];
      status_word[8] = ovr_flag;
      status_word[7] = r.download_checksum_ok;
      status_word[6] = r.run_ok;
      status_word[5] = r.custom;
      status_word[4] = !r.ctrl1[c1_third];
      status_word[3] = 1'b1;
      status_word[2:0] = r.ctrl1[2:0];
   end

   assign write_hit = word_valid && (r.phase == wait_data);

   // Next state of the whole register set
   always_comb begin
      next_r = r;
      // Die pins pass two flops before use
      next_r.die_meta = die_pins;
      next_r.die = r.die_meta;
      // Action bits last one cycle only
      next_r.sync = 1'b0;
      next_r.dl_start = 1'b0;
      next_r.ctrl1[c1_sync] = 1'b0;
      next_r.ctrl1[c1_dl] = 1'b0;
      next_r.rd_valid = 1'b0;
      if (conv_valid) begin
         next_r.last_conv = conv_data;
      end

      // Address word first, then its data word
      if (word_valid) begin
         case (r.phase)
            wait_addr: begin
               next_r.addr = word_data[2:0];
               next_r.phase = wait_data;
            end
            wait_data: begin
               next_r.phase = wait_addr;
            end
            default: begin
               next_r.phase = wait_addr;
            end
         endcase
      end

      if (write_hit) begin
         case (r.addr)
            addr_ctrl1: begin
               next_r.ctrl1 = word_data;
               next_r.ctrl1[c1_zero] = 1'b0;
               next_r.sync = word_data[c1_sync];
               next_r.dl_start = word_data[c1_dl];
            end
            addr_power: begin
               // Bit 1 stored as the host sends it
               next_r.power = word_data;
            end
            addr_offset: begin
               next_r.offset = word_data;
            end
            addr_gain: begin
               next_r.gain = word_data;
            end
            addr_thresh: begin
               next_r.thresh = word_data;
            end
            default: begin
               next_r.addr = r.addr; // Unmapped address, write dropped
            end
         endcase
      end

      // A new download voids the old filter state
      if (next_r.dl_start) begin
         next_r.dl_sum = 32'h0;
         next_r.download_checksum_ok = 1'b0;
         next_r.custom = 1'b0;
         next_r.run_ok = 1'b0;
      end else if (dl_sum_valid) begin
         next_r.download_checksum_ok = (r.dl_sum == dl_sum_word);
         next_r.custom = (r.dl_sum == dl_sum_word);
         next_r.stored_sum = dl_sum_word;
         next_r.dl_sum = 32'h0;
      end else if (dl_coef_valid) begin
         next_r.dl_sum = r.dl_sum + dl_coef;
      end

      // Runtime checksum over coefficients in flight
      if (run_pass_done) begin
         next_r.run_ok = r.custom && (r.run_sum == r.stored_sum);
         next_r.run_sum = 32'h0;
      end else if (run_coef_valid && r.custom) begin
         next_r.run_sum = r.run_sum + run_coef;
      end

      // Read answers one word; selects clear once used
      if (read_strobe) begin
         next_r.rd_valid = 1'b1;
         if (r.ctrl1[c1_rd_stat]) begin
            next_r.rd_data = {8'h00, status_word};
         end else if (r.ctrl1[c1_rd_ovr]) begin
            next_r.rd_data = {8'h00, r.thresh};
         end else if (r.ctrl1[c1_rd_gain]) begin
            next_r.rd_data = {8'h00, r.gain};
         end else if (r.ctrl1[c1_rd_off]) begin
            next_r.rd_data = {8'h00, r.offset};
         end else begin
            next_r.rd_data = r.last_conv;
         end
         next_r.ctrl1[c1_rd_ovr:c1_rd_stat] = 4'h0;
      end
   end

   // Register set, reset to the documented defaults
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.phase <= wait_addr;
         r.ctrl1 <= rst_ctrl1;
         r.power <= rst_power;
         r.offset <= rst_offset;
         r.gain <= rst_gain;
         r.thresh <= rst_thresh;
      end else begin
         r <= next_r;
      end
   end

   // Power controls straight from their register bits
   assign low_power_select = r.power[pwr_low];
   assign amp_power_down = r.power[pwr_amp_pd];
   assign chip_power_down = r.power[pwr_chip_pd];
   assign third_stage_enable = r.ctrl1[c1_third];
   assign decimation_select = r.ctrl1[2:0];
   assign sync_pulse = r.sync;
   assign download_start = r.dl_start;
   assign read_valid = r.rd_valid;
   assign read_data = r.rd_data;
   assign data_valid = conv_valid;
   assign data_out = conv_data;
endmodule : adc_config_status_registers

// [bench/host_model.sv]
// Purpose: host controller model on the register word interface
// Assumes: device takes one word per clock edge with word_valid high
// Notes: idle word lines carry junk so stale data never passes
`timescale 1ns/1ns
module host_model
   import adc_reg_pkg::*;
(
   // Clock
   input wire logic clk,
   // Toward the device
   output logic word_valid,
   output logic [15:0] word_data,
   output logic read_strobe,
   // From the device
   input wire logic read_valid,
   input wire logic [23:0] read_data
);
   // Quiet bus at start
   initial begin
      word_valid = 1'b0;
      word_data = 16'h5a5a;
      read_strobe = 1'b0;
   end

   // Address word, then data word, back to back
   task automatic write_reg(input logic [2:0] addr, input logic [15:0] data);
      logic [15:0] d;
      d = (addr == addr_power) ? (data | 16'h0002) : data;
      @(posedge clk);
      word_valid <= 1'b1;
      word_data <= {13'h0000, addr};
      @(posedge clk);
      word_data <= d;
      @(posedge clk);
      word_valid <= 1'b0;
      word_data <= ~d; // Junk, not the last value
      // Return off the edge so callers see the new register value
      @(negedge clk);
   endtask : write_reg

   // One strobe, bounded wait for the answer
   task automatic read_word(output logic [23:0] data, output bit ok);
      ok = 1'b0;
      data = 24'hxxxxxx;
      @(posedge clk);
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk);
         ok = read_valid;
         data = read_data;
      end
   endtask : read_word
endmodule : host_model

// [bench/adc_config_status_registers_props.sv]
// Purpose: port-level checks of the register block
// Assumes: single clock, async active-high reset
// Notes: power and control outputs may only move the cycle after a word
`timescale 1ns/1ns
module adc_config_status_registers_props (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Inputs watched
   input wire logic word_valid,
   input wire logic read_strobe,
   input wire logic filt_valid,
   // Outputs watched
   input wire logic read_valid,
   input wire logic [23:0] read_data,
   input wire logic data_valid,
   input wire logic [23:0] data_out,
   input wire logic low_power_select,
   input wire logic amp_power_down,
   input wire logic chip_power_down,
   input wire logic third_stage_enable,
   input wire logic [2:0] decimation_select,
   input wire logic download_start
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_read_answer: assert property (read_strobe |=> read_valid)
      else $error("read answer missing");
   a_read_unasked: assert property (!read_strobe |=> !read_valid)
      else $error("read answer without request");
   a_read_hold: assert property (!read_strobe |=> $stable(read_data))
      else $error("read data moved without request");
   a_power_hold: assert property (!word_valid |=> $stable({low_power_select,
      amp_power_down, chip_power_down})) else $error("power bits moved without write");
   a_ctrl_hold: assert property (!word_valid |=>
      $stable({third_stage_enable, decimation_select})) else $error("control moved");
   a_data_latency: assert property (filt_valid && !chip_power_down && !word_valid
      |=> data_valid) else $error("corrected sample missing");
   a_data_unasked: assert property (!filt_valid |=> !data_valid)
      else $error("corrected sample without input");
   a_data_hold: assert property (!filt_valid |=> $stable(data_out))
      else $error("output word moved without input");
   a_dl_pulse: assert property (download_start |=> !download_start)
      else $error("download start too long");
endmodule : adc_config_status_registers_props

bind adc_config_status_registers adc_config_status_registers_props props_u (.clk, .sys_rst,
   .word_valid, .read_strobe, .filt_valid, .read_valid, .read_data, .data_valid, .data_out,
   .low_power_select, .amp_power_down, .chip_power_down, .third_stage_enable,
   .decimation_select, .download_start);

// [bench/testbench.sv]
// Purpose: directed scenarios for the register block
// Assumes: host_model drives the word interface
// Notes: status expectations kept in a local shadow
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
   import adc_reg_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic word_valid, read_strobe, read_valid, data_valid, sync_pulse, download_start;
   logic low_power_select, amp_power_down, chip_power_down, third_stage_enable;
   logic [15:0] word_data;
   logic [23:0] read_data, data_out, rd;
   logic [2:0] decimation_select, die_pins = 3'h5;
   logic s1_valid = 1'b0, mod_valid = 1'b0, mod_over_full = 1'b0, filt_valid = 1'b0;
   logic dl_coef_valid = 1'b0, dl_sum_valid = 1'b0, run_coef_valid = 1'b0;
   logic run_pass_done = 1'b0;
   logic [23:0] s1_data = 24'h000000, filt_data = 24'h000000;
   logic [31:0] dl_coef = 32'h0, dl_sum_word = 32'h0, run_coef = 32'h0;
   logic [15:0] c1 = 16'h001a; // Shadow of the first control register
   wire [2:0] pwr = {low_power_select, amp_power_down, chip_power_down};
   int fails = 0;
   int num_checks = 0;
   bit ok;

   always #2 clk = ~clk;

   host_model host_u (.clk, .word_valid, .word_data, .read_strobe, .read_valid, .read_data);
   adc_config_status_registers dut_u (.clk, .sys_rst, .word_valid, .word_data, .read_strobe,
      .read_valid, .read_data, .die_pins, .s1_valid, .s1_data, .mod_valid, .mod_over_full,
      .filt_valid, .filt_data, .dl_coef_valid, .dl_coef, .dl_sum_valid, .dl_sum_word,
      .run_coef_valid, .run_coef, .run_pass_done, .low_power_select, .amp_power_down,
      .chip_power_down, .third_stage_enable, .decimation_select, .sync_pulse,
      .download_start, .data_valid, .data_out);

   // Counts, verdict, end of run
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   // Expected status word; f is low power, overrange, download_checksum_ok, run ok, custom
   function automatic logic [23:0] stat(input logic [4:0] f);
      return {8'h00, part_code, 3'h5, 1'b0, f, ~c1[4], 1'b1, c1[2:0]};
   endfunction : stat

   // Select one register through control word, then read it
   task automatic rd_sel(input logic [15:0] sel);
      host_u.write_reg(addr_ctrl1, c1 | sel);
      host_u.read_word(rd, ok);
      if (!ok) begin
         fails++;
         stop_test();
      end
   endtask : rd_sel

   // Reset values of outputs, correction registers and status
   task automatic t_reset;
      logic [15:0] rv [3] = '{16'hcccc, 16'ha000, 16'h0000};
      `CHK("outs", 7'h3a, {pwr, third_stage_enable, decimation_select})
      for (int i = 0; i < 3; i++) begin
         rd_sel(16'h4000 >> i);
         `CHK("reg", {8'h00, rv[i]}, rd)
      end
      rd_sel(16'h0800);
      `CHK("status", stat(5'h00), rd)
   endtask : t_reset

   // Every power bit alone, status follows low power
   task automatic t_power;
      logic [15:0] pv [4] = '{16'h0004, 16'h0001, 16'h0008, 16'h0000};
      c1 = 16'h000d;
      host_u.write_reg(addr_ctrl1, c1);
      `CHK("ctrl", 4'h5, {third_stage_enable, decimation_select})
      for (int i = 0; i < 4; i++) begin
         host_u.write_reg(addr_power, pv[i]);
         `CHK("power", {pv[i][2], pv[i][0], pv[i][3]}, pwr)
         rd_sel(16'h0800);
         `CHK("status", stat({pv[i][2], 4'h0}), rd)
      end
   endtask : t_power

   // Gain first, then offset; negative full offset too
   task automatic t_data;
      logic [15:0] g [2] = '{16'h4000, 16'h8000};
      logic [15:0] o [2] = '{16'h0010, 16'h8000};
      logic [23:0] e [2] = '{24'h008010, 24'h008000};
      for (int i = 0; i < 2; i++) begin
         host_u.write_reg(addr_gain, g[i]);
         host_u.write_reg(addr_offset, o[i]);
         @(posedge clk);
         filt_valid <= 1'b1;
         filt_data <= 24'h010000;
         @(posedge clk);
         filt_valid <= 1'b0;
         filt_data <= 24'hfeffff;
         @(posedge clk);
         `CHK("data", {1'b1, e[i]}, {data_valid, data_out})
      end
   endtask : t_data

   // One first-filter sample
   task automatic s1_put(input logic [23:0] d);
      @(posedge clk);
      s1_valid <= 1'b1;
      s1_data <= d;
      @(posedge clk);
      s1_valid <= 1'b0;
   endtask : s1_put

   // Threshold compare, then runs of 4 and 5 full-scale samples
   task automatic t_ovr;
      host_u.write_reg(addr_thresh, 16'h0100);
      s1_put(24'h004000);
      rd_sel(16'h0800);
      `CHK("ovr low", 1'b0, rd[8])
      s1_put(24'hff0000);
      rd_sel(16'h0800);
      `CHK("ovr high", 1'b1, rd[8])
      s1_put(24'h004000);
      for (int n = 4; n < 6; n++) begin
         repeat (n) begin
            @(posedge clk);
            mod_valid <= 1'b1;
            mod_over_full <= 1'b1;
         end
         @(posedge clk);
         mod_over_full <= 1'b0;
         @(posedge clk);
         mod_valid <= 1'b0;
         rd_sel(16'h0800);
         `CHK("ovr run", n == 5, rd[8])
      end
   endtask : t_ovr

   // Bad download, then a good one, then a good and a bad pass
   task automatic t_sum;
      logic [31:0] cf [3] = '{32'h00010000, 32'h00000e6b, 32'h12345678};
      for (int k = 0; k < 2; k++) begin
         host_u.write_reg(addr_ctrl1, c1 | 16'h8200);
         `CHK("pulses", 2'h3, {sync_pulse, download_start})
         for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            dl_coef_valid <= 1'b1;
            dl_coef <= cf[j];
         end
         @(posedge clk);
         dl_coef_valid <= 1'b0;
         dl_sum_valid <= 1'b1;
         dl_sum_word <= cf[0] + cf[1] + cf[2] + (1 - k);
         @(posedge clk);
         dl_sum_valid <= 1'b0;
         rd_sel(16'h0800);
         `CHK("dl", {2{k == 1}}, {rd[7], rd[5]})
      end
      // Clean pass must match, a corrupted pass must not
      for (int p = 0; p < 2; p++) begin
         for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            run_coef_valid <= j < 3;
            run_coef <= cf[j % 3] + p;
            run_pass_done <= j == 3;
         end
         @(posedge clk);
         run_pass_done <= 1'b0;
         rd_sel(16'h0800);
         `CHK("run", p == 0, rd[6])
      end
   endtask : t_sum

   // Reset for six cycles, then the scenarios
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_power();
      t_data();
      t_ovr();
      t_sum();
      stop_test();
   end
endmodule : testbench
